// ===== hw/lnb_ctrl_pkg.sv
// shared constants for the supply-controller two-wire link
package lnb_ctrl_pkg;
  // -------------------------------------------------------------------------
  // bus address
  // -------------------------------------------------------------------------
  localparam logic [6:0] ADDR_BASE = 7'h08;
  localparam logic [1:0] ADDR_SEL_RESET = 2'h0;
  // -------------------------------------------------------------------------
  // control byte fields
  // -------------------------------------------------------------------------
  localparam int PULSED_LIMIT_BIT = 7;
  localparam int CURRENT_SEL_BIT = 6;
  localparam int TONE_FORCE_BIT = 5;
  localparam int LINE_COMP_BIT = 4;
  localparam int VOLT_SEL_BIT = 3;
  localparam int ENABLE_BIT = 2;
  localparam int THERMAL_BIT = 1;
  localparam int OVERLOAD_BIT = 0;
  localparam logic [7:0] CTRL_WR_MASK = 8'hFC;
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic [3:0] BITS_PER_BYTE = 4'h8;
  // -------------------------------------------------------------------------
  // master timing
  // -------------------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 5;
  localparam int SCL_HALF_NS = 250;
  localparam int SCL_HALF_CYC = (SCL_HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // -------------------------------------------------------------------------
  // master register map (avalon word addresses)
  // -------------------------------------------------------------------------
  localparam logic [1:0] REG_CMD = 2'h0;
  localparam logic [1:0] REG_WDATA = 2'h1;
  localparam logic [1:0] REG_STATUS = 2'h2;
  localparam logic [1:0] REG_RDATA = 2'h3;
  localparam int CMD_GO_BIT = 0;
  localparam int CMD_READ_BIT = 1;
  localparam int CMD_ASEL_LO = 2;
endpackage : lnb_ctrl_pkg

// ===== hw/lnb_link_if.sv
// two-wire link between the supply controller and its host master
`timescale 1ns/100ps
`default_nettype none
interface lnb_link_if;
  logic scl_o;
  logic scl_oe;
  logic sda_m_o;
  logic sda_m_oe;
  logic sda_s_o;
  logic sda_s_oe;
  wire logic scl;
  wire logic sda;
  // -------------------------------------------------------------------------
  // open-drain wired and with pull-ups
  // -------------------------------------------------------------------------
  assign scl = scl_oe ? scl_o : 1'b1;
  assign sda = (sda_m_oe ? sda_m_o : 1'b1) & (sda_s_oe ? sda_s_o : 1'b1);
  modport host (output scl_o, output scl_oe, output sda_m_o, output sda_m_oe,
    input scl, input sda);
  modport device (output sda_s_o, output sda_s_oe, input scl, input sda);
endinterface : lnb_link_if
`default_nettype wire

// ===== hw/lnb_supply_i2c_slave_ctrl.sv
// device end: two-wire slave holding the supply control byte
//
// Decided for this implementation: the address map and the Avalon-MM interface to the registers.
`timescale 1ns/100ps
`default_nettype none
module lnb_supply_i2c_slave_ctrl
(
  input wire logic clk,
  input wire logic nrst,
  lnb_link_if.device link,
  input wire logic [1:0] addr_select,
  input wire logic uvlo,
  input wire logic thermal_shutdown_flag,
  input wire logic overload_flag,
  input wire logic tone_key_input,
  input wire logic carrier_22k,
  input wire logic tone_detector_input,
  output logic tone_out,
  output logic tone_detect_output_o,
  output logic tone_detect_output_oe,
  output logic loop_switch_closed,
  output logic [7:0] system_control_byte
);
  typedef enum logic [2:0]
  {
    ST_IDLE = 3'b000,
    ST_ADDR = 3'b001,
    ST_WDATA = 3'b010,
    ST_RDATA = 3'b011,
    ST_IGNORE = 3'b100
  } slave_state_t;
  // -------------------------------------------------------------------------
  // synchronisers
  // -------------------------------------------------------------------------
  logic [1:0] scl_sync_q;
  logic [1:0] sda_sync_q;
  logic scl_last_q;
  logic sda_last_q;
  logic [1:0] det_sync_q;
  logic [1:0] key_sync_q;
  logic [1:0] asel_sync_q;
  logic [1:0] uvlo_sync_q;
  logic [3:0] flag_sync_q;
  always_ff @(posedge clk)
  begin
    if (!nrst)
    begin
      scl_sync_q <= 2'h3;
      sda_sync_q <= 2'h3;
      scl_last_q <= 1'b1;
      sda_last_q <= 1'b1;
      det_sync_q <= 2'h0;
      key_sync_q <= 2'h0;
      asel_sync_q <= 2'h0;
      uvlo_sync_q <= 2'h0;
      flag_sync_q <= 4'h0;
    end
    else
    begin
      scl_sync_q <= {scl_sync_q[0], link.scl};
      sda_sync_q <= {sda_sync_q[0], link.sda};
      scl_last_q <= scl_sync_q[1];
      sda_last_q <= sda_sync_q[1];
      det_sync_q <= {det_sync_q[0], tone_detector_input};
      key_sync_q <= {key_sync_q[0], tone_key_input};
      asel_sync_q <= {asel_sync_q[0], addr_select[0]};
      uvlo_sync_q <= {uvlo_sync_q[0], uvlo};
      flag_sync_q <= {flag_sync_q[1:0], thermal_shutdown_flag, overload_flag};
    end
  end
  logic scl_s;
  logic sda_s;
  logic uvlo_s;
  assign uvlo_s = uvlo_sync_q[1];
  logic scl_rise;
  logic scl_fall;
  logic start_det;
  logic stop_det;
  assign scl_s = scl_sync_q[1];
  assign sda_s = sda_sync_q[1];
  assign scl_rise = scl_s & ~scl_last_q;
  assign scl_fall = ~scl_s & scl_last_q;
  assign start_det = scl_s & scl_last_q & sda_last_q & ~sda_s;
  assign stop_det = scl_s & scl_last_q & ~sda_last_q & sda_s;
  // strap: only bit 0 passed the slow path above; bit 1 via its own pair
  logic [1:0] asel1_sync_q;
  logic [1:0] asel_q;
  always_ff @(posedge clk)
  begin
    if (!nrst)
    begin
      asel1_sync_q <= 2'h0;
      asel_q <= lnb_ctrl_pkg::ADDR_SEL_RESET;
    end
    else
    begin
      asel1_sync_q <= {asel1_sync_q[0], addr_select[1]};
      asel_q <= {asel1_sync_q[1], asel_sync_q[1]};
    end
  end
  logic [6:0] my_addr;
  assign my_addr = lnb_ctrl_pkg::ADDR_BASE | {5'h00, asel_q};
  // -------------------------------------------------------------------------
  // byte engine
  // -------------------------------------------------------------------------
  slave_state_t state_q;
  logic [3:0] bit_cnt_q;
  logic [7:0] shift_q;
  logic ack_phase_q;
  logic drive_low_q;
  logic master_nack_q;
  logic [7:0] ctrl_q;
  logic [7:0] read_byte;
  assign read_byte = {ctrl_q[7:2], flag_sync_q[3:2]};
  always_ff @(posedge clk)
  begin
    if (!nrst || uvlo_s)
    begin
      state_q <= ST_IDLE;
      bit_cnt_q <= 4'h0;
      shift_q <= 8'h00;
      ack_phase_q <= 1'b0;
      drive_low_q <= 1'b0;
      master_nack_q <= 1'b0;
    end
    else if (start_det)
    begin
      state_q <= ST_ADDR;
      master_nack_q <= 1'b0;
      bit_cnt_q <= 4'h0;
      ack_phase_q <= 1'b0;
      drive_low_q <= 1'b0;
    end
    else if (stop_det)
    begin
      state_q <= ST_IDLE;
      drive_low_q <= 1'b0;
      ack_phase_q <= 1'b0;
    end
    else if (state_q != ST_IDLE && state_q != ST_IGNORE)
    begin
      if (scl_rise && !ack_phase_q)
      begin
        shift_q <= {shift_q[6:0], sda_s};
        bit_cnt_q <= bit_cnt_q + 4'h1;
      end
      else if (scl_rise && ack_phase_q && state_q == ST_RDATA)
      begin
        master_nack_q <= sda_s;
      end
      if (scl_fall)
      begin
        if (!ack_phase_q && bit_cnt_q == lnb_ctrl_pkg::BITS_PER_BYTE)
        begin
          ack_phase_q <= 1'b1;
          bit_cnt_q <= 4'h0;
          case (state_q)
            ST_ADDR:
            begin
              if (shift_q[7:1] == my_addr)
              begin
                drive_low_q <= 1'b0;
                state_q <= shift_q[0] ? ST_RDATA : ST_WDATA;
              end
              else
              begin
                state_q <= ST_IGNORE;
              end
              drive_low_q <= (shift_q[7:1] == my_addr);
            end
            ST_WDATA:
            begin
              drive_low_q <= 1'b1;
            end
            default:
            begin
              drive_low_q <= 1'b0;
            end
          endcase
        end
        else if (ack_phase_q)
        begin
          ack_phase_q <= 1'b0;
          drive_low_q <= 1'b0;
          if (state_q == ST_RDATA && !master_nack_q && shift_q[0])
          begin
            state_q <= ST_RDATA;
          end
          if (state_q == ST_RDATA && master_nack_q)
          begin
            state_q <= ST_IGNORE;
          end
        end
        else if (state_q == ST_RDATA)
        begin
          drive_low_q <= 1'b0;
        end
      end
    end
  end
  // -------------------------------------------------------------------------
  // read shifter: loads on the ack fall, shifts on later falls
  // -------------------------------------------------------------------------
  logic [7:0] tx_q;
  logic [3:0] tx_cnt_q;
  logic tx_active_q;
  always_ff @(posedge clk)
  begin
    if (!nrst || uvlo_s || start_det || stop_det)
    begin
      tx_q <= 8'hFF;
      tx_cnt_q <= 4'h0;
      tx_active_q <= 1'b0;
    end
    else if (scl_fall && ack_phase_q && state_q == ST_RDATA && !master_nack_q)
    begin
      tx_q <= read_byte;
      tx_cnt_q <= 4'h0;
      tx_active_q <= 1'b1;
    end
    else if (scl_fall && ack_phase_q && state_q == ST_RDATA)
    begin
      tx_active_q <= 1'b0;
    end
    else if (scl_fall && tx_active_q && !ack_phase_q)
    begin
      if (tx_cnt_q == lnb_ctrl_pkg::BITS_PER_BYTE - 4'h1)
      begin
        tx_active_q <= 1'b0;
      end
      else
      begin
        tx_q <= {tx_q[6:0], 1'b1};
        tx_cnt_q <= tx_cnt_q + 4'h1;
      end
    end
  end
  // sda only moves on scl falls or on lockout (uvlo_s), so it is stable while scl is high outside lockout
  assign link.sda_s_o = 1'b0;
  assign link.sda_s_oe = (drive_low_q | (tx_active_q & ~tx_q[7])) & ~uvlo_s;
  // -------------------------------------------------------------------------
  // control byte
  // -------------------------------------------------------------------------
  always_ff @(posedge clk)
  begin
    if (!nrst || uvlo_s)
    begin
      ctrl_q <= lnb_ctrl_pkg::CTRL_RESET;
    end
    else if (state_q == ST_WDATA && scl_fall && !ack_phase_q
      && bit_cnt_q == lnb_ctrl_pkg::BITS_PER_BYTE)
    begin
      ctrl_q <= shift_q & lnb_ctrl_pkg::CTRL_WR_MASK;
    end
  end
  assign system_control_byte = read_byte;
  // -------------------------------------------------------------------------
  // tone and loop-through
  // -------------------------------------------------------------------------
  always_ff @(posedge clk)
  begin
    if (!nrst)
    begin
      tone_out <= 1'b0;
      tone_detect_output_oe <= 1'b0;
      loop_switch_closed <= 1'b1;
    end
    else
    begin
      tone_out <= ctrl_q[lnb_ctrl_pkg::ENABLE_BIT] & carrier_22k
        & (ctrl_q[lnb_ctrl_pkg::TONE_FORCE_BIT] | key_sync_q[1]);
      tone_detect_output_oe <= det_sync_q[1];
      loop_switch_closed <= ~ctrl_q[lnb_ctrl_pkg::ENABLE_BIT];
    end
  end
  assign tone_detect_output_o = 1'b0;
endmodule : lnb_supply_i2c_slave_ctrl
`default_nettype wire

// ===== hw/lnb_host_master.sv
// host end: avalon-controlled two-wire master for one-byte transfers
`timescale 1ns/100ps
`default_nettype none
module lnb_host_master
(
  input wire logic clk,
  input wire logic nrst,
  input wire logic [1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  lnb_link_if.host link
);
  typedef enum logic [2:0]
  {
    M_IDLE = 3'b000,
    M_START = 3'b001,
    M_BIT = 3'b010,
    M_STOP = 3'b011,
    M_DONE = 3'b100
  } master_state_t;
  // -------------------------------------------------------------------------
  // register slave
  // -------------------------------------------------------------------------
  logic rd_ack_q;
  logic [7:0] wdata_q;
  logic [7:0] rdata_q;
  logic go;
  logic busy;
  logic nack_q;
  logic rnw_q;
  logic [1:0] asel_q;
  master_state_t st_q;
  assign busy = st_q != M_IDLE;
  assign avs_waitrequest = avs_read & ~rd_ack_q;
  assign go = avs_write && avs_address == lnb_ctrl_pkg::REG_CMD && !busy
    && avs_writedata[lnb_ctrl_pkg::CMD_GO_BIT];
  always_ff @(posedge clk)
  begin
    if (!nrst)
    begin
      rd_ack_q <= 1'b0;
      avs_readdata <= 32'h0000_0000;
    end
    else
    begin
      rd_ack_q <= avs_read & ~rd_ack_q;
      if (avs_read && !rd_ack_q)
      begin
        if (avs_address == lnb_ctrl_pkg::REG_STATUS)
          avs_readdata <= {30'h0000_0000, nack_q, busy};
        else if (avs_address == lnb_ctrl_pkg::REG_RDATA)
          avs_readdata <= {24'h00_0000, rdata_q};
        else if (avs_address == lnb_ctrl_pkg::REG_WDATA)
          avs_readdata <= {24'h00_0000, wdata_q};
        else
          avs_readdata <= 32'h0000_0000;
      end
    end
  end
  always_ff @(posedge clk)
  begin
    if (!nrst)
    begin
      wdata_q <= 8'h00;
      rnw_q <= 1'b0;
      asel_q <= 2'h0;
    end
    else if (avs_write && avs_address == lnb_ctrl_pkg::REG_WDATA)
      wdata_q <= avs_writedata[7:0];
    else if (go)
    begin
      rnw_q <= avs_writedata[lnb_ctrl_pkg::CMD_READ_BIT];
      asel_q <= avs_writedata[lnb_ctrl_pkg::CMD_ASEL_LO +: 2];
    end
  end
  // -------------------------------------------------------------------------
  // bit engine: 18 bits = address+ack, data+ack; quarter phases of scl
  // -------------------------------------------------------------------------
  logic [7:0] tick_q;
  logic [1:0] ph_q;
  logic [4:0] idx_q;
  logic [17:0] frame_q;
  logic scl_q;
  logic sda_q;
  logic tick;
  assign tick = tick_q == 8'(lnb_ctrl_pkg::SCL_HALF_CYC - 1);
  always_ff @(posedge clk)
  begin
    if (!nrst || st_q == M_IDLE || tick)
      tick_q <= 8'h00;
    else
      tick_q <= tick_q + 8'h01;
  end
  always_ff @(posedge clk)
  begin
    if (!nrst)
    begin
      st_q <= M_IDLE;
      ph_q <= 2'h0;
      idx_q <= 5'h00;
      frame_q <= 18'h3FFFF;
      scl_q <= 1'b1;
      sda_q <= 1'b1;
      nack_q <= 1'b0;
      rdata_q <= 8'h00;
    end
    else if (go)
    begin
      st_q <= M_START;
      nack_q <= 1'b0;
      frame_q <= {lnb_ctrl_pkg::ADDR_BASE | {5'h00, avs_writedata[3:2]},
        avs_writedata[lnb_ctrl_pkg::CMD_READ_BIT], 1'b1,
        avs_writedata[lnb_ctrl_pkg::CMD_READ_BIT] ? 8'hFF : wdata_q, 1'b1};
    end
    else if (tick)
    begin
      case (st_q)
        M_START:
        begin
          sda_q <= 1'b0;
          st_q <= M_BIT;
          idx_q <= 5'h00;
          ph_q <= 2'h0;
        end
        M_BIT:
        begin
          ph_q <= ph_q + 2'h1;
          if (ph_q == 2'h0)
            scl_q <= 1'b0;
          else if (ph_q == 2'h1)
            sda_q <= frame_q[17];
          else if (ph_q == 2'h2)
            scl_q <= 1'b1;
          else
          begin
            if (idx_q == 5'd8 || (idx_q == 5'd17 && !rnw_q))
              nack_q <= nack_q | link.sda;
            if (rnw_q && idx_q > 5'd8 && idx_q < 5'd17)
              rdata_q <= {rdata_q[6:0], link.sda};
            frame_q <= {frame_q[16:0], 1'b1};
            idx_q <= idx_q + 5'h01;
            if (idx_q == 5'd17 || (idx_q == 5'd8 && link.sda))
              st_q <= M_STOP;
          end
        end
        M_STOP:
        begin
          ph_q <= ph_q + 2'h1;
          if (ph_q == 2'h0)
            scl_q <= 1'b0;
          else if (ph_q == 2'h1)
            sda_q <= 1'b0;
          else if (ph_q == 2'h2)
            scl_q <= 1'b1;
          else
          begin
            sda_q <= 1'b1;
            st_q <= M_DONE;
          end
        end
        default:
          st_q <= M_IDLE;
      endcase
    end
  end
  // the single read byte ends with a released sda (master no-ack)
  assign link.scl_o = 1'b0;
  assign link.scl_oe = ~scl_q;
  assign link.sda_m_o = 1'b0;
  assign link.sda_m_oe = ~sda_q;
endmodule : lnb_host_master
`default_nettype wire

// ===== verif/lnb_link_sva.sv
// link checker: timing relations on the shared two-wire lines
`timescale 1ns/100ps
`default_nettype none
module lnb_link_sva
(
  input wire logic clk,
  input wire logic nrst,
  input wire logic uvlo,
  input wire logic scl,
  input wire logic sda,
  input wire logic sda_m_oe,
  input wire logic sda_s_o,
  input wire logic sda_s_oe
);
  // --------------------------------------------------------------------------
  // bus event tracking
  // --------------------------------------------------------------------------
  logic scl_q;
  logic sda_q;
  logic idle_q;
  logic [3:0] rise_q;
  logic start_ev;
  logic stop_ev;
  assign start_ev = scl && scl_q && sda_q && !sda;
  assign stop_ev = scl && scl_q && !sda_q && sda;
  always_ff @(posedge clk)
  begin
    scl_q <= scl;
    sda_q <= sda;
  end
  // the bus rests between a stop and the next start
  always_ff @(posedge clk)
  begin
    if (!nrst || stop_ev)
      idle_q <= 1'b1;
    else if (start_ev)
      idle_q <= 1'b0;
  end
  // saturates at 15 so that a long transfer never wraps back into the address byte and its ack slot
  always_ff @(posedge clk)
  begin
    if (!nrst || start_ev)
      rise_q <= 4'h0;
    else if (scl && !scl_q && rise_q != 4'hF)
      rise_q <= rise_q + 4'h1;
  end
  // --------------------------------------------------------------------------
  // assertions
  // --------------------------------------------------------------------------
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!nrst);
  slave_edge_low_a: assert property ($changed(sda_s_oe) |-> !scl)
    else $error("device moved sda while scl high");
  addr_stable_a: assert property (scl && $past(scl) && rise_q inside {[4'h1:4'h8]}
    |-> $stable(sda)) else $error("sda moved inside an address bit");
  ack_drive_low_a: assert property (sda_s_oe |-> !sda_s_o)
    else $error("device drives sda high");
  ack_slot_a: assert property ($rose(sda_s_oe) && rise_q < 4'h9 |-> rise_q == 4'h8)
    else $error("address ack not after the eighth bit");
  ack_pulse_a: assert property ($rose(sda_s_oe) && rise_q == 4'h8
    |-> ##[1:300] (scl && sda_s_oe)) else $error("ack not held into the clock pulse");
  idle_silent_a: assert property (idle_q |-> !sda_s_oe)
    else $error("device drives sda while bus idle");
  start_listen_a: assert property (start_ev |=> !sda_s_oe [*8])
    else $error("device drives sda right after start");
  uvlo_silent_a: assert property (uvlo [*4] |-> !sda_s_oe)
    else $error("device answers during lockout");
  stop_first_a: assert property (start_ev |-> idle_q)
    else $error("start without preceding stop");
  master_release_a: assert property (sda_s_oe && scl |-> !sda_m_oe)
    else $error("master drives sda in device slot");
endmodule : lnb_link_sva
`default_nettype wire

// ===== verif/lnb_supply_i2c_slave_ctrl_tb.sv
// bench: host master and device joined over the link, driven through avalon
`timescale 1ns/100ps
`default_nettype none
module lnb_supply_i2c_slave_ctrl_tb;
  typedef struct {string nm; logic [31:0] m; logic [31:0] v;} note_t;
  localparam int EN = lnb_ctrl_pkg::ENABLE_BIT;
  localparam int TF = lnb_ctrl_pkg::TONE_FORCE_BIT;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic [1:0] avs_address = 2'h0;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h00000000;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic [1:0] addr_select = 2'h0;
  logic uvlo = 1'b0;
  logic thermal = 1'b0;
  logic overload = 1'b0;
  logic key = 1'b0;
  logic carrier = 1'b0;
  logic det = 1'b0;
  logic tone_out;
  logic det_o;
  logic det_oe;
  logic loop_closed;
  logic [7:0] ctrl_byte;
  logic mon_chk = 1'b0;
  note_t exp_q[$];
  note_t got;
  int error_cnt = 0;
  int total_checks = 0;
  lnb_link_if link();
  lnb_host_master i_lnb_host_master (.clk(clk), .nrst(nrst), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .link(link.host));
  lnb_supply_i2c_slave_ctrl i_lnb_supply_i2c_slave_ctrl (.clk(clk), .nrst(nrst),
    .link(link.device), .addr_select(addr_select), .uvlo(uvlo),
    .thermal_shutdown_flag(thermal), .overload_flag(overload), .tone_key_input(key),
    .carrier_22k(carrier), .tone_detector_input(det), .tone_out(tone_out),
    .tone_detect_output_o(det_o), .tone_detect_output_oe(det_oe),
    .loop_switch_closed(loop_closed), .system_control_byte(ctrl_byte));
  lnb_link_sva i_lnb_link_sva (.clk(clk), .nrst(nrst), .uvlo(uvlo), .scl(link.scl),
    .sda(link.sda), .sda_m_oe(link.sda_m_oe), .sda_s_o(link.sda_s_o),
    .sda_s_oe(link.sda_s_oe));
  always #2.5 clk = ~clk;
  // --------------------------------------------------------------------------
  // reporting and bus tasks
  // --------------------------------------------------------------------------
  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask : check
  task automatic end_sim();
    $display("checks %0d mismatches %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : end_sim
  task automatic hang(input string nm);
    error_cnt++;
    $display("CHECK FAILED %s expected done seen timeout", nm);
    end_sim();
  endtask : hang
  // sampled just before the rising edge that completes the request
  task automatic wait_ack();
    int n;
    n = 0;
    @(negedge clk);
    while (avs_waitrequest !== 1'b0)
    begin
      n++;
      if (n > 50)
        hang("waitrequest");
      @(negedge clk);
    end
  endtask : wait_ack
  task automatic av_write(input logic [1:0] a, input logic [31:0] d);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= 1'b1;
    wait_ack();
    @(posedge clk);
    avs_write <= 1'b0;
    @(posedge clk);
  endtask : av_write
  task automatic av_read(input logic [1:0] a, input bit chk, input note_t nt,
    output logic [31:0] d);
    if (chk)
      exp_q.push_back(nt);
    avs_address <= a;
    avs_read <= 1'b1;
    mon_chk <= chk;
    wait_ack();
    d = avs_readdata;
    @(posedge clk);
    avs_read <= 1'b0;
    mon_chk <= 1'b0;
    @(posedge clk);
  endtask : av_read
  // one frame: start, address, ack, byte, ack, stop; an unacked address goes straight to stop
  task automatic xfer(input bit rd, input logic [1:0] asel, input logic [7:0] wd,
    input logic nack, input logic [7:0] rbyte);
    logic [31:0] d;
    int n;
    av_write(lnb_ctrl_pkg::REG_WDATA, {24'h000000, wd});
    av_write(lnb_ctrl_pkg::REG_CMD, {28'h0000000, asel, rd, 1'b1});
    repeat (4) @(posedge clk);
    n = 0;
    do
    begin
      av_read(lnb_ctrl_pkg::REG_STATUS, 1'b0, '{"", 32'h00000000, 32'h00000000}, d);
      n++;
      if (n > 4000)
        hang("busy");
    end while (d[0] !== 1'b0);
    av_read(lnb_ctrl_pkg::REG_STATUS, 1'b1, '{"nack", 32'h00000003, 32'({nack, 1'b0})}, d);
    if (rd)
      av_read(lnb_ctrl_pkg::REG_RDATA, 1'b1, '{"rbyte", 32'h000000FF, 32'(rbyte)}, d);
  endtask : xfer
  // --------------------------------------------------------------------------
  // result monitor and main sequence
  // --------------------------------------------------------------------------
  always @(negedge clk)
  begin
    if (mon_chk && avs_read && avs_waitrequest === 1'b0 && exp_q.size() > 0)
    begin
      got = exp_q.pop_front();
      check(got.nm, avs_readdata & got.m, got.v);
    end
  end
  initial
  begin
    logic [7:0] wd;
    logic [7:0] held;
    logic [1:0] flags;
    logic [1:0] a;
    void'($urandom(32'h000022DA));
    held = 8'h00;
    repeat (10) @(posedge clk);
    nrst <= 1'b1;
    repeat (4) @(posedge clk);
    check("reset byte", 32'(ctrl_byte), 32'h00000000);
    check("reset loop", 32'(loop_closed), 32'h00000001);
    check("detect level", 32'(det_o), 32'h00000000);
    $display("test reset done");
    for (int i = 0; i < 4; i++)
    begin
      a = 2'(i);
      flags = 2'($urandom());
      wd = 8'($urandom());
      wd[EN] = a[0];
      wd[TF] = a[1];
      addr_select <= a;
      thermal <= flags[1];
      overload <= flags[0];
      repeat (8) @(posedge clk);
      if (i == 0)
      begin
        xfer(1'b0, a + 2'h1, wd, 1'b1, 8'h00);
        check("byte kept", 32'(ctrl_byte), 32'(held | {6'h00, flags}));
      end
      xfer(1'b0, a, wd, 1'b0, 8'h00);
      held = wd & lnb_ctrl_pkg::CTRL_WR_MASK;
      check("byte written", 32'(ctrl_byte), 32'(held | {6'h00, flags}));
      xfer(1'b1, a, 8'h00, 1'b0, held | {6'h00, flags});
      check("loop switch", 32'(loop_closed), 32'(!wd[EN]));
      for (int k = 0; k < 4; k++)
      begin
        key <= k[0];
        carrier <= k[1];
        det <= k[0];
        repeat (8) @(posedge clk);
        check("tone", 32'(tone_out), 32'(wd[EN] & k[1] & (wd[TF] | k[0])));
        check("detect drive", 32'(det_oe), 32'(k[0]));
      end
      $display("test address %0d done", i);
    end
    uvlo <= 1'b1;
    repeat (8) @(posedge clk);
    check("lockout byte", 32'(ctrl_byte & lnb_ctrl_pkg::CTRL_WR_MASK), 32'h00000000);
    xfer(1'b0, a, 8'hFF, 1'b1, 8'h00);
    check("lockout write", 32'(ctrl_byte & lnb_ctrl_pkg::CTRL_WR_MASK), 32'h00000000);
    uvlo <= 1'b0;
    repeat (8) @(posedge clk);
    $display("test lockout done");
    end_sim();
  end
endmodule : lnb_supply_i2c_slave_ctrl_tb
`default_nettype wire
